// [hdl/ext_bus_pkg.sv]
// constants and carriers of the external bus strobe and wait-state logic
// Function
// - read strobe low only during an external memory read cycle.
// - read strobe and output-enable strobe are one permanently shared output.
// - external device holds ready low to lengthen a cycle; device honours it.
// - second configuration byte fetch gets first configuration byte's 0-3 minimum waits.
// - chip-select range accesses get that channel's programmed 0-3 minimum waits.
// - after minimum reached, add one wait at a time until ready is high.
// - write strobe low only during an external memory write cycle.
// - pin in special role: config bit set gives combined write, clear gives low-byte write.
package ext_bus_pkg;

  // ****************************************************************
  // widths and codes
  // ****************************************************************
  localparam int unsigned WAIT_W     = 2;
  localparam int unsigned CS_NUM     = 6;
  localparam int unsigned CS_W       = 3;
  localparam int unsigned WSEL_BIT   = 2;
  localparam logic [1:0]  WAIT_RST   = 2'h3;
  localparam logic [7:0]  CFG_REG_RST = 8'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic            write;
    logic            cfg1_fetch;
    logic [CS_W-1:0] cs_sel;
  } bus_req_t;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic wr_low_n;
  } strobe_t;

  localparam strobe_t STROBE_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, wr_low_n: 1'b1};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MIN  = 2'b01,
    ST_RDY  = 2'b11,
    ST_END  = 2'b10
  } bus_state_t;

endpackage

// [hdl/ext_bus_read_wait_control.sv]
// external bus read/write strobes with programmed and ready wait states
`timescale 1ns/1ns
`default_nettype none
module ext_bus_read_wait_control #(
  parameter int unsigned CS_NUM = ext_bus_pkg::CS_NUM
) (
  // clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_i,
  // core request
  input  wire logic                                 req_i,
  input  wire ext_bus_pkg::bus_req_t                req_info_i,
  output logic                                      busy_o,
  output logic                                      done_o,
  // configuration
  input  wire logic [ext_bus_pkg::WAIT_W-1:0]       config_byte_zero_wait_i,
  input  wire logic [CS_NUM*ext_bus_pkg::WAIT_W-1:0] chip_select_bus_control_wait_i,
  input  wire logic [7:0]                           chip_config_reg_zero_i,
  input  wire logic                                 write_special_i,
  // pins
  input  wire logic                                 ready_i,
  output logic                                      rd_oe_n_o,
  output logic                                      wr_pin_n_o,
  output logic                                      write_low_strobe_n_o
);

  ext_bus_pkg::bus_state_t state_ff;
  ext_bus_pkg::bus_state_t nxt_state;
  logic                    write_ff;
  logic                    nxt_write;
  ext_bus_pkg::strobe_t    strobe_ff;
  ext_bus_pkg::strobe_t    nxt_strobe;
  logic [ext_bus_pkg::WAIT_W-1:0] min_wait;
  logic                    load;
  logic                    cnt_zero;
  logic                    cs_valid;
  logic [ext_bus_pkg::WAIT_W-1:0] cs_wait [CS_NUM];
  logic [ext_bus_pkg::WAIT_W-1:0] cs_min_wait;
  logic                    st_idle;
  logic                    st_min;
  logic                    st_rdy;
  logic                    st_end;
  logic                    ready_seen;
  logic                    nxt_min;
  logic                    nxt_rdy;
  logic                    in_cycle;
  logic                    rd_cycle;
  logic                    wr_cycle;
  logic                    pin_special;
  logic                    pin_combined;
  logic                    wr_pin;

  // ****************************************************************
  // state decode
  // ****************************************************************
  assign st_idle = (state_ff == ext_bus_pkg::ST_IDLE);
  assign st_min  = (state_ff == ext_bus_pkg::ST_MIN);
  assign st_rdy  = (state_ff == ext_bus_pkg::ST_RDY);
  assign st_end  = (state_ff == ext_bus_pkg::ST_END);

  // ****************************************************************
  // per-channel minimum waits
  // ****************************************************************
  for (genvar ch = 0; ch < CS_NUM; ch++) begin : g_cs_wait
    assign cs_wait[ch] =
      chip_select_bus_control_wait_i[ch*ext_bus_pkg::WAIT_W +: ext_bus_pkg::WAIT_W];
  end

  // ****************************************************************
  // chip-select range check
  // ****************************************************************
  assign cs_valid = (32'(req_info_i.cs_sel) < CS_NUM);

  // ****************************************************************
  // chip-select minimum lookup
  // ****************************************************************
  always_comb begin
    cs_min_wait = ext_bus_pkg::WAIT_RST;
    for (int ch = 0; ch < CS_NUM; ch++) begin
      if (32'(req_info_i.cs_sel) == 32'(ch)) begin
        cs_min_wait = cs_wait[ch];
      end
    end
  end

  // ****************************************************************
  // minimum wait selection
  // ****************************************************************
  always_comb begin
    if (req_info_i.cfg1_fetch) begin
      min_wait = config_byte_zero_wait_i;
    end else if (cs_valid) begin
      min_wait = cs_min_wait;
    end else begin
      min_wait = ext_bus_pkg::WAIT_RST;
    end
  end

  // ****************************************************************
  // programmed minimum counter
  // ****************************************************************
  assign load = st_idle && req_i;

  wait_counter #(
    .WIDTH (ext_bus_pkg::WAIT_W)
  ) u_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (load),
    .value_i (min_wait),
    .tick_i  (st_min),
    .zero_o  (cnt_zero)
  );

  // ****************************************************************
  // ready sampling
  // ****************************************************************
  assign ready_seen = st_rdy && ready_i;

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_write = write_ff;
    unique case (state_ff)
      ext_bus_pkg::ST_IDLE: begin
        if (req_i) begin
          nxt_state = ext_bus_pkg::ST_MIN;
          nxt_write = req_info_i.write;
        end
      end
      ext_bus_pkg::ST_MIN: begin
        if (cnt_zero) begin
          nxt_state = ext_bus_pkg::ST_RDY;
        end
      end
      ext_bus_pkg::ST_RDY: begin
        if (ready_seen) begin
          nxt_state = ext_bus_pkg::ST_END;
        end
      end
      ext_bus_pkg::ST_END: begin
        nxt_state = ext_bus_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // next-state decode
  // ****************************************************************
  assign nxt_min = (nxt_state == ext_bus_pkg::ST_MIN);
  assign nxt_rdy = (nxt_state == ext_bus_pkg::ST_RDY);

  // ****************************************************************
  // strobes
  // ****************************************************************
  assign in_cycle = nxt_min || nxt_rdy;
  assign rd_cycle = in_cycle && !nxt_write;
  assign wr_cycle = in_cycle && nxt_write;

  always_comb begin
    nxt_strobe = ext_bus_pkg::STROBE_IDLE;
    if (wr_cycle) begin
      nxt_strobe.wr_n     = 1'b0;
      nxt_strobe.wr_low_n = 1'b0;
    end
    if (rd_cycle) begin
      nxt_strobe.rd_n = 1'b0;
    end
  end

  // ****************************************************************
  // sequencer registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ext_bus_pkg::ST_IDLE;
      write_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      write_ff <= nxt_write;
    end
  end

  // ****************************************************************
  // strobe registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_ff <= ext_bus_pkg::STROBE_IDLE;
    end else begin
      strobe_ff <= nxt_strobe;
    end
  end

  // ****************************************************************
  // shared write pin
  // ****************************************************************
  assign pin_special  = write_special_i;
  assign pin_combined = chip_config_reg_zero_i[ext_bus_pkg::WSEL_BIT];

  always_comb begin
    wr_pin = 1'b1;
    if (pin_special) begin
      if (pin_combined) begin
        wr_pin = strobe_ff.wr_n;
      end else begin
        wr_pin = strobe_ff.wr_low_n;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rd_oe_n_o            = strobe_ff.rd_n;
  assign write_low_strobe_n_o = strobe_ff.wr_low_n;
  assign wr_pin_n_o           = wr_pin;
  assign busy_o               = !st_idle;
  assign done_o               = st_end;

endmodule // ext_bus_read_wait_control
`default_nettype wire

// [hdl/wait_counter.sv]
// counter of programmed minimum wait states
`timescale 1ns/1ns
`default_nettype none
module wait_counter #(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  input  wire logic             tick_i,
  // status
  output logic                  zero_o
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;

  // ****************************************************************
  // next count
  // ****************************************************************
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load_i) begin
      nxt_cnt = value_i;
    end else if (tick_i && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign zero_o = (cnt_ff == '0);

endmodule // wait_counter
`default_nettype wire

// [test/ext_bus_assertions.sv]
// checker of strobe and wait-state timing
`timescale 1ns/1ns
`default_nettype none
module ext_bus_checker #(parameter int unsigned CS_NUM = 6) (
  // watched ports
  input wire logic                                  clk_i,
  input wire logic                                  rst_i,
  input wire logic                                  req_i,
  input wire ext_bus_pkg::bus_req_t                 req_info_i,
  input wire logic                                  busy_o,
  input wire logic                                  done_o,
  input wire logic [ext_bus_pkg::WAIT_W-1:0]        config_byte_zero_wait_i,
  input wire logic [CS_NUM*ext_bus_pkg::WAIT_W-1:0] chip_select_bus_control_wait_i,
  input wire logic [7:0]                            chip_config_reg_zero_i,
  input wire logic                                  write_special_i,
  input wire logic                                  ready_i,
  input wire logic                                  rd_oe_n_o,
  input wire logic                                  wr_pin_n_o,
  input wire logic                                  write_low_strobe_n_o
);
  logic       wr_ff;
  logic       sl;
  logic [1:0] mn_ff;
  logic [5:0] cnt_ff;
  assign sl = !rd_oe_n_o || !write_low_strobe_n_o;
  // access kind, minimum and strobe length
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ff  <= 1'b0;
      mn_ff  <= 2'h0;
      cnt_ff <= 6'h0;
    end else if (req_i && !busy_o) begin
      wr_ff  <= req_info_i.write;
      mn_ff  <= req_info_i.cfg1_fetch ? config_byte_zero_wait_i :
                req_info_i.cs_sel < CS_NUM ?
                chip_select_bus_control_wait_i[req_info_i.cs_sel*2 +: 2] : 2'h3;
      cnt_ff <= 6'h0;
    end else if (sl) begin
      cnt_ff <= cnt_ff + 6'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RD_ONLY: assert property (!rd_oe_n_o |-> busy_o && !wr_ff)
    else $error("read strobe outside read");
  AST_WR_ONLY: assert property (!write_low_strobe_n_o |-> busy_o && wr_ff)
    else $error("write strobe outside write");
  AST_START: assert property (req_i && !busy_o |=> (rd_oe_n_o == wr_ff) && sl)
    else $error("strobe start wrong");
  AST_PIN_OFF: assert property (!write_special_i |-> wr_pin_n_o)
    else $error("write pin active in port role");
  AST_PIN_LOW: assert property (write_special_i && !chip_config_reg_zero_i[2]
    |-> wr_pin_n_o == write_low_strobe_n_o)
    else $error("write pin not low-byte strobe");
  AST_MIN: assert property ($fell(sl) |-> cnt_ff >= mn_ff + 2)
    else $error("strobe shorter than minimum");
  AST_HOLD: assert property (sl && !ready_i && cnt_ff > mn_ff |=> sl)
    else $error("ready low not honoured");
  AST_RISE: assert property (sl && ready_i && cnt_ff > mn_ff |=> !sl)
    else $error("extra wait with ready high");
  AST_DONE: assert property ($fell(sl) |-> done_o)
    else $error("done missing at strobe end");
endmodule // ext_bus_checker
`default_nettype wire

// [test/mem_model.sv]
// memory model driving the ready pin
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  // pins and stall length
  input wire logic       clk_i,
  input wire logic       rd_n_i,
  input wire logic       wr_n_i,
  input wire logic [3:0] stall_i,
  output logic           ready_o
);
  logic [3:0] cnt_ff;
  always_ff @(posedge clk_i) begin
    cnt_ff <= (rd_n_i && wr_n_i) ? 4'h0 : cnt_ff + 4'h1;
  end
  // ready low for stall cycles of strobe, pulled high when idle
  assign ready_o = (rd_n_i && wr_n_i) || cnt_ff >= stall_i;
endmodule // mem_model
`default_nettype wire

// [test/tb_top.sv]
// bench of the external bus strobe and wait-state logic
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_i = 0, rst_i = 1, req_i = 0, sp = 1, rdy, busy, done, rd, wp, wl;
  ext_bus_pkg::bus_req_t info = '0;
  logic [7:0] ccr = 8'h04;
  logic [1:0] cb0 = 2'h2;
  logic [3:0] stall = 4'h0;
  int fails = 0, cmp_count = 0, cyc = 0;
  // {write,cfg,0,0} cs stall strobe-cycles
  logic [15:0] rows [10] = '{16'h0002, 16'h8305, 16'h0167, 16'hc004, 16'h0705,
                             16'h8545, 16'h0434, 16'h0234, 16'h4304, 16'h0605};
  ext_bus_read_wait_control dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .req_info_i(info), .busy_o(busy), .done_o(done), .config_byte_zero_wait_i(cb0),
    .chip_select_bus_control_wait_i(12'h9e4), .chip_config_reg_zero_i(ccr),
    .write_special_i(sp), .ready_i(rdy), .rd_oe_n_o(rd), .wr_pin_n_o(wp),
    .write_low_strobe_n_o(wl));
  mem_model mem (.clk_i(clk_i), .rd_n_i(rd), .wr_n_i(wl), .stall_i(stall), .ready_o(rdy));
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic access(input logic [15:0] r);
    logic [7:0] nr, nw, np;
    int k;
    @(negedge clk_i);
    info = '{r[15], r[14], r[10:8]};
    stall = r[7:4];
    req_i = 1;
    @(negedge clk_i);
    req_i = 0;
    nr = 0; nw = 0; np = 0; k = 0;
    while (done !== 1'b1 && k < 40) begin
      nr += 8'(rd === 1'b0);
      nw += 8'(wl === 1'b0);
      np += 8'(wp === 1'b0);
      k++;
      @(negedge clk_i);
    end
    chk(nr, r[15] ? 8'h0 : 8'(r[3:0]));
    chk(nw, r[15] ? 8'(r[3:0]) : 8'h0);
    chk(np, (r[15] && sp) ? 8'(r[3:0]) : 8'h0);
  endtask
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 2000) begin fails++; stop_test(); end
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 0;
    foreach (rows[i]) access(rows[i]);
    sp = 0;
    access(16'h8305);
    sp = 1;
    ccr = 8'h00;
    access(16'h8545);
    cb0 = 2'h0;
    access(16'h4002);
    @(negedge clk_i);
    info = '0;
    stall = 4'h6;
    req_i = 1;
    @(negedge clk_i);
    req_i = 0;
    @(negedge clk_i);
    rst_i = 1;
    #1 chk({rd, wl, busy, done}, 8'hc);
    @(negedge clk_i);
    rst_i = 0;
    access(16'h0167);
    stop_test();
  end
endmodule // tb_top
bind ext_bus_read_wait_control ext_bus_checker #(.CS_NUM(CS_NUM)) chk (.*);
`default_nettype wire
